// >>> rtl/cas_core_state.sv
// Purpose: Architectural state of the core: banked registers, PC sequencing,
//          delay slot tracking, endianness, link reservation, trap capture
// Assumes: One retirement per enabled cycle; execute stage resolves hazards
// Notes:   Registers are flip-flops; one synchronous read port pair
//          A trap in the same cycle as a retirement wins; the retirement is lost
//          The endian strap is sampled once after reset and then ignored
//
// Behaviour
// RULE1: Register zero always reads as zero
// RULE2: Register width fixed at 32 or 64
// RULE3: Register access uses current shadow set
// RULE4: Memory endianness latched at reset release
// RULE5: Load/store endianness is memory XOR swap
// RULE6: Swap active only in user mode
// RULE7: Reservation set by linked load, cleared otherwise
// RULE8: PC advances 2 or 4 when unassigned
// RULE9: Taken branch applies after delay slot
// RULE10: Restart address written to link or trap
// RULE11: One-bit instruction width mode register
// RULE12: Restart address carries width mode bit
// RULE13: Effects land within own instruction time
// RULE14: Effects of one instruction apply in order
// RULE15: Delay slot flag reflects dynamic execution
// RULE16: Trap carries type, argument, abandons instruction
// RULE17: FPR width follows status width bit
// RULE18: Physical address width is a parameter
// RULE19: FP condition zero mirrors coprocessor signal
// RULE20: Writes to register zero discarded
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps
module cas_core_state #(
  parameter int REG_WIDTH   = cas_pkg::REG_WIDTH_DEF,
  parameter int SHADOW_SETS = cas_pkg::SHADOW_SETS_DEF,
  parameter int PHYS_ADDR_W = cas_pkg::PHYS_ADDR_DEF,
  parameter int SET_W       = (SHADOW_SETS > 1) ? $clog2(SHADOW_SETS) : 1
) (
  input  wire logic                              core_clk_i,
  input  wire logic                              resetn_i,
  input  wire logic                              clk_en_i,
  input  wire logic                              cfg_big_endian_i,
  input  wire logic [SET_W-1:0]                  current_shadow_set_i,
  input  wire logic                              reverse_endian_bit_i,
  input  wire logic                              user_mode_i,
  input  wire logic                              float_reg_width_bit_i,
  input  wire logic                              coproc_condition_signal_i,
  input  wire logic [cas_pkg::REG_IDX_W-1:0]     rd_a_idx_i,
  input  wire logic [cas_pkg::REG_IDX_W-1:0]     rd_b_idx_i,
  input  wire logic                              wr_en_i,
  input  wire logic [cas_pkg::REG_IDX_W-1:0]     wr_idx_i,
  input  wire logic [REG_WIDTH-1:0]              wr_data_i,
  input  wire cas_pkg::cas_retire_t              retire_i,
  input  wire cas_pkg::cas_trap_t                trap_i,
  output logic [REG_WIDTH-1:0]                   rd_a_data_o,
  output logic [REG_WIDTH-1:0]                   rd_b_data_o,
  output logic [cas_pkg::ADDR_WIDTH-1:0]         pc_o,
  output logic [PHYS_ADDR_W-1:0]                 phys_pc_o,
  output logic                                   instruction_width_mode_o,
  output logic                                   in_delay_slot_flag_o,
  output logic                                   mem_big_endian_o,
  output logic                                   cpu_big_endian_o,
  output logic                                   user_endian_swap_o,
  output logic                                   link_reservation_flag_o,
  output logic                                   cond_store_ok_o,
  output logic                                   fpr_width_select_o,
  output logic                                   fpu_condition_code_o,
  output logic                                   trap_valid_o,
  output logic [cas_pkg::TRAP_CODE_W-1:0]        trap_code_o,
  output logic [cas_pkg::TRAP_ARG_W-1:0]         trap_arg_o,
  output logic [cas_pkg::ADDR_WIDTH-1:0]         trap_restart_o
);

  localparam int NUM_REGS = cas_pkg::NUM_REGS;

  // Config strap is a pin: two flops before use
  logic cfg_meta_q;
  logic cfg_sync_q;
  logic strap_taken_q;
  logic strap_taken_d;
  logic mem_be_q;
  logic mem_be_d;
  logic cfg_meta_d;
  logic cfg_sync_d;
  logic [1:0] sync_fill_q;
  logic [1:0] sync_fill_d;

  logic [REG_WIDTH-1:0] regs_q [SHADOW_SETS][NUM_REGS];
  logic [REG_WIDTH-1:0] rd_a_q;
  logic [REG_WIDTH-1:0] rd_b_q;
  logic [REG_WIDTH-1:0] rd_a_d;
  logic [REG_WIDTH-1:0] rd_b_d;

  logic [cas_pkg::ADDR_WIDTH-1:0] pc_q;
  logic [cas_pkg::ADDR_WIDTH-1:0] pc_d;
  logic [cas_pkg::ADDR_WIDTH-1:0] pend_tgt_q;
  logic [cas_pkg::ADDR_WIDTH-1:0] pend_tgt_d;
  logic                           pend_q;
  logic                           pend_d;
  logic                           dslot_q;
  logic                           dslot_d;
  logic                           mode_q;
  logic                           mode_d;
  logic                           link_reservation_flag_q;
  logic                           link_reservation_flag_d;
  logic                           trap_vld_q;
  logic                           trap_vld_d;
  logic [cas_pkg::TRAP_CODE_W-1:0] trap_code_q;
  logic [cas_pkg::TRAP_CODE_W-1:0] trap_code_d;
  logic [cas_pkg::TRAP_ARG_W-1:0]  trap_arg_q;
  logic [cas_pkg::TRAP_ARG_W-1:0]  trap_arg_d;
  logic [cas_pkg::ADDR_WIDTH-1:0]  trap_rst_q;
  logic [cas_pkg::ADDR_WIDTH-1:0]  trap_rst_d;

  logic                           link_we;
  logic [REG_WIDTH-1:0]           link_val;
  logic [cas_pkg::ADDR_WIDTH-1:0] restart_addr;
  logic                           swap;
  logic                           retire_ok;

  // Strap synchroniser; first flop feeds only the second
  always_comb begin
    cfg_meta_d  = cfg_big_endian_i;
    cfg_sync_d  = cfg_meta_q;
    // Fill marks when the second flop holds a sampled strap, not its reset value
    sync_fill_d = {sync_fill_q[0], 1'b1};
  end

  // Runs while frozen so the strap is ready whenever the core is enabled
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      cfg_meta_q  <= 1'b0;
      cfg_sync_q  <= 1'b0;
      sync_fill_q <= 2'h0;
    end else begin
      cfg_meta_q  <= cfg_meta_d;
      cfg_sync_q  <= cfg_sync_d;
      sync_fill_q <= sync_fill_d;
    end
  end

  // RULE4: strap capture once
  always_comb begin
    strap_taken_d = strap_taken_q;
    mem_be_d      = mem_be_q;
    if (!strap_taken_q && sync_fill_q[1]) begin
      strap_taken_d = 1'b1;
      mem_be_d      = cfg_sync_q;
    end
  end

  // Capture waits until the synchroniser has been filled after release
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      strap_taken_q <= 1'b0;
      mem_be_q      <= cas_pkg::ENDIAN_LITTLE;
    end else if (clk_en_i) begin
      strap_taken_q <= strap_taken_d;
      mem_be_q      <= mem_be_d;
    end
  end

  // RULE6: swap only in user mode
  assign swap = reverse_endian_bit_i & user_mode_i;
  // RULE5: effective load/store order
  assign cpu_big_endian_o   = mem_be_q ^ swap;
  assign user_endian_swap_o = swap;
  assign mem_big_endian_o   = mem_be_q;

  // RULE17: FPR width select
  assign fpr_width_select_o = float_reg_width_bit_i ? cas_pkg::FPR_WIDE : cas_pkg::FPR_NARROW;
  // RULE19: condition code zero mirror
  assign fpu_condition_code_o = coproc_condition_signal_i;

  // RULE12: upper PC bits merged with width mode
  assign restart_addr = {pc_q[cas_pkg::ADDR_WIDTH-1:1], mode_q};

  // RULE10: link write of restart address, suppressed when trapping
  assign link_we = retire_i.valid && retire_i.link_write && !trap_i.raise;
  always_comb begin
    link_val = '0;
    link_val[cas_pkg::ADDR_WIDTH-1:0] = restart_addr;
  end

  // RULE3: reads select the current shadow set
  always_comb begin
    rd_a_d = regs_q[current_shadow_set_i][rd_a_idx_i];
    rd_b_d = regs_q[current_shadow_set_i][rd_b_idx_i];
    // RULE1: register zero reads zero
    if (rd_a_idx_i == cas_pkg::ZERO_REG) begin
      rd_a_d = '0;
    end
    if (rd_b_idx_i == cas_pkg::ZERO_REG) begin
      rd_b_d = '0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      rd_a_q <= '0;
      rd_b_q <= '0;
    end else if (clk_en_i) begin
      rd_a_q <= rd_a_d;
      rd_b_q <= rd_b_d;
    end
  end
  assign rd_a_data_o = rd_a_q;
  assign rd_b_data_o = rd_b_q;

  // RULE2: each entry is REG_WIDTH wide
  genvar gs;
  genvar gr;
  generate
    for (gs = 0; gs < SHADOW_SETS; gs++) begin : g_set
      for (gr = 0; gr < NUM_REGS; gr++) begin : g_reg
        logic [REG_WIDTH-1:0] nxt;
        always_comb begin
          nxt = regs_q[gs][gr];
          // RULE14: link write follows the data write
          if (wr_en_i && !trap_i.raise && wr_idx_i == (cas_pkg::REG_IDX_W)'(gr)
              && current_shadow_set_i == (SET_W)'(gs)) begin
            nxt = wr_data_i;
          end
          if (link_we && retire_i.link_reg == (cas_pkg::REG_IDX_W)'(gr)
              && current_shadow_set_i == (SET_W)'(gs)) begin
            nxt = link_val;
          end
          // RULE20: register zero write discard
          // Register zero keeps its flops so every bank has one shape
          if (gr == 0) begin
            nxt = '0;
          end
        end
        always_ff @(posedge core_clk_i) begin
          if (!resetn_i) begin
            regs_q[gs][gr] <= '0;
          end else if (clk_en_i) begin
            regs_q[gs][gr] <= nxt;
          end
        end
      end
    end
  endgenerate

  // RULE16: trap abandons rest of instruction
  // Mode and reservation only move for a retirement that no trap overrides
  assign retire_ok = retire_i.valid && !trap_i.raise;

  // RULE13: all sequencing updates in the retiring cycle
  always_comb begin
    pc_d       = pc_q;
    pend_d     = pend_q;
    pend_tgt_d = pend_tgt_q;
    dslot_d    = dslot_q;
    if (trap_i.raise) begin
      // A pending branch dies with the trapped instruction
      pend_d  = 1'b0;
      dslot_d = 1'b0;
    end else if (retire_i.valid) begin
      // RULE8: default advance by 2 or 4
      pc_d = pc_q + (retire_i.short_insn ? cas_pkg::PC_STEP_SHORT : cas_pkg::PC_STEP_WORD);
      if (retire_i.pc_assign) begin
        pc_d = retire_i.pc_value;
      end
      // RULE9: pending target applies in slot
      if (pend_q) begin
        pc_d = pend_tgt_q;
      end
      // RULE15: flag tracks actual delay slot
      // A branch sitting in a delay slot is not taken again
      dslot_d    = retire_i.branch_taken && !pend_q;
      pend_d     = retire_i.branch_taken && !pend_q;
      pend_tgt_d = retire_i.branch_target;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      pc_q       <= cas_pkg::PC_RESET;
      pend_q     <= 1'b0;
      pend_tgt_q <= '0;
      dslot_q    <= 1'b0;
    end else if (clk_en_i) begin
      pc_q       <= pc_d;
      pend_q     <= pend_d;
      pend_tgt_q <= pend_tgt_d;
      dslot_q    <= dslot_d;
    end
  end

  // RULE11: width mode register update
  always_comb begin
    mode_d = mode_q;
    if (retire_ok && retire_i.mode_assign) begin
      mode_d = retire_i.mode_value;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      mode_q <= cas_pkg::MODE_WIDE;
    end else if (clk_en_i) begin
      mode_q <= mode_d;
    end
  end

  // RULE7: reservation set and clear
  always_comb begin
    link_reservation_flag_d = link_reservation_flag_q;
    if (retire_ok && retire_i.linked_load) begin
      link_reservation_flag_d = 1'b1;
    end
    // A clear beats a set so a broken sequence can never pass a store
    if (retire_ok && (retire_i.cond_store || retire_i.break_atomic || retire_i.exc_return)) begin
      link_reservation_flag_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      link_reservation_flag_q <= 1'b0;
    end else if (clk_en_i) begin
      link_reservation_flag_q <= link_reservation_flag_d;
    end
  end

  // RULE16: trap carries type and argument
  always_comb begin
    trap_vld_d  = 1'b0;
    trap_code_d = trap_code_q;
    trap_arg_d  = trap_arg_q;
    trap_rst_d  = trap_rst_q;
    if (trap_i.raise) begin
      trap_vld_d  = 1'b1;
      trap_code_d = trap_i.code;
      trap_arg_d  = trap_i.arg;
      // RULE10: restart address to system register
      trap_rst_d  = restart_addr;
    end
  end

  // Code, argument and restart hold after the one-cycle valid pulse
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      trap_vld_q  <= 1'b0;
      trap_code_q <= '0;
      trap_arg_q  <= '0;
      trap_rst_q  <= '0;
    end else if (clk_en_i) begin
      trap_vld_q  <= trap_vld_d;
      trap_code_q <= trap_code_d;
      trap_arg_q  <= trap_arg_d;
      trap_rst_q  <= trap_rst_d;
    end
  end

  assign pc_o                     = pc_q;
  // RULE18: physical address is low bits
  assign phys_pc_o                = pc_q[PHYS_ADDR_W-1:0];
  assign instruction_width_mode_o = mode_q;
  assign in_delay_slot_flag_o     = dslot_q;
  assign link_reservation_flag_o  = link_reservation_flag_q;
  assign cond_store_ok_o          = link_reservation_flag_q;
  assign trap_valid_o             = trap_vld_q;
  assign trap_code_o              = trap_code_q;
  assign trap_arg_o               = trap_arg_q;
  assign trap_restart_o           = trap_rst_q;

endmodule

// >>> rtl/cas_pkg.sv
// Purpose: Shared constants and types for the core architectural state block
// Assumes: Single clock, synchronous active-low reset
// Notes:   Widths and counts used by the state block live here, except SET_W, which the block derives itself
package cas_pkg;

  localparam int          REG_WIDTH_DEF   = 32;
  localparam int          SHADOW_SETS_DEF = 2;
  localparam int          PHYS_ADDR_DEF   = 32;
  localparam int          ADDR_WIDTH      = 32;
  localparam int          REG_IDX_W       = 5;
  localparam int          NUM_REGS        = 32;
  localparam logic [4:0]  ZERO_REG        = 5'h00;
  localparam logic [31:0] PC_STEP_SHORT   = 32'h00000002;
  localparam logic [31:0] PC_STEP_WORD    = 32'h00000004;
  localparam logic [31:0] PC_RESET        = 32'h00000000;
  localparam logic        ENDIAN_LITTLE   = 1'b0;
  localparam logic        ENDIAN_BIG      = 1'b1;
  localparam logic        MODE_WIDE       = 1'b0;
  localparam logic        MODE_COMPRESSED = 1'b1;
  localparam logic        FPR_NARROW      = 1'b0;
  localparam logic        FPR_WIDE        = 1'b1;
  localparam int          TRAP_CODE_W     = 5;
  localparam int          TRAP_ARG_W      = 32;

  // One retiring instruction as reported by the execute stage
  typedef struct packed {
    logic                   valid;
    logic                   short_insn;
    logic                   pc_assign;
    logic [ADDR_WIDTH-1:0]  pc_value;
    logic                   branch_taken;
    logic [ADDR_WIDTH-1:0]  branch_target;
    logic                   link_write;
    logic [REG_IDX_W-1:0]   link_reg;
    logic                   mode_assign;
    logic                   mode_value;
    logic                   linked_load;
    logic                   cond_store;
    logic                   break_atomic;
    logic                   exc_return;
  } cas_retire_t;

  typedef struct packed {
    logic                   raise;
    logic [TRAP_CODE_W-1:0] code;
    logic [TRAP_ARG_W-1:0]  arg;
  } cas_trap_t;

endpackage

// >>> verification/cas_core_state_sva.sv
// Purpose: Port-level assertions for the state block
// Assumes: One clock; checks are off while reset is low
// Notes:   Bound to every instance of the design below
`timescale 1ns/1ps
module cas_core_state_sva #(
  parameter int REG_WIDTH = 32
) (
  input wire logic                 core_clk_i,
  input wire logic                 resetn_i,
  input wire logic                 clk_en_i,
  input wire logic                 reverse_endian_bit_i,
  input wire logic                 user_mode_i,
  input wire logic                 float_reg_width_bit_i,
  input wire logic                 coproc_condition_signal_i,
  input wire logic [4:0]           rd_a_idx_i,
  input wire cas_pkg::cas_retire_t retire_i,
  input wire cas_pkg::cas_trap_t   trap_i,
  input wire logic [REG_WIDTH-1:0] rd_a_data_o,
  input wire logic [31:0]          pc_o,
  input wire logic                 instruction_width_mode_o,
  input wire logic                 in_delay_slot_flag_o,
  input wire logic                 mem_big_endian_o,
  input wire logic                 cpu_big_endian_o,
  input wire logic                 user_endian_swap_o,
  input wire logic                 link_reservation_flag_o,
  input wire logic                 fpr_width_select_o,
  input wire logic                 fpu_condition_code_o,
  input wire logic                 trap_valid_o,
  input wire logic [4:0]           trap_code_o,
  input wire logic [31:0]          trap_restart_o
);
  logic [31:0] restart_now;
  assign restart_now = {pc_o[31:1], instruction_width_mode_o};
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  // A retirement that no trap overrides
  sequence s_ret;
    clk_en_i && retire_i.valid && !trap_i.raise;
  endsequence
  sequence s_plain;
    s_ret ##0 !in_delay_slot_flag_o;
  endsequence
  AST_ZERO_READ: assert property (clk_en_i && rd_a_idx_i == 5'h00 |=> rd_a_data_o == '0)
    else $error("register zero read nonzero");
  AST_SWAP: assert property (user_endian_swap_o == (reverse_endian_bit_i && user_mode_i))
    else $error("swap outside user mode");
  AST_CPU_END: assert property (cpu_big_endian_o == (mem_big_endian_o ^ user_endian_swap_o))
    else $error("load store order wrong");
  AST_FPR: assert property (fpr_width_select_o == float_reg_width_bit_i)
    else $error("fpr width wrong");
  AST_FCC: assert property (fpu_condition_code_o == coproc_condition_signal_i)
    else $error("condition code wrong");
  AST_PC_STEP: assert property (s_plain ##0 !retire_i.pc_assign |=> pc_o == $past(pc_o)
    + ($past(retire_i.short_insn) ? cas_pkg::PC_STEP_SHORT : cas_pkg::PC_STEP_WORD))
    else $error("pc step wrong");
  AST_PC_SET: assert property (s_plain ##0 retire_i.pc_assign |=> pc_o == $past(pc_o) + 0
    - $past(pc_o) + $past(retire_i.pc_value))
    else $error("pc assign lost");
  AST_SLOT_SET: assert property (s_plain ##0 retire_i.branch_taken |=> in_delay_slot_flag_o)
    else $error("slot flag not set");
  AST_SLOT_END: assert property (s_ret ##0 in_delay_slot_flag_o |=> !in_delay_slot_flag_o)
    else $error("slot flag stuck");
  AST_LL_CLR: assert property (s_ret ##0 (retire_i.exc_return || retire_i.cond_store
    || retire_i.break_atomic) |=> !link_reservation_flag_o)
    else $error("reservation not cleared");
  AST_MODE: assert property (s_ret ##0 retire_i.mode_assign
    |=> instruction_width_mode_o == $past(retire_i.mode_value))
    else $error("width mode not taken");
  AST_TRAP: assert property (clk_en_i && trap_i.raise |=> trap_valid_o
    && trap_code_o == $past(trap_i.code) && trap_restart_o == $past(restart_now))
    else $error("trap capture wrong");
  AST_TRAP_PULSE: assert property (trap_valid_o && clk_en_i && !trap_i.raise
    |=> !trap_valid_o)
    else $error("trap pulse too long");
  AST_FREEZE: assert property (!clk_en_i |=> $stable(pc_o) && $stable(link_reservation_flag_o))
    else $error("state moved while frozen");
endmodule

bind cas_core_state cas_core_state_sva #(.REG_WIDTH(REG_WIDTH)) u_sva (
  .core_clk_i, .resetn_i, .clk_en_i, .reverse_endian_bit_i, .user_mode_i,
  .float_reg_width_bit_i, .coproc_condition_signal_i, .rd_a_idx_i, .retire_i, .trap_i,
  .rd_a_data_o, .pc_o, .instruction_width_mode_o, .in_delay_slot_flag_o, .mem_big_endian_o,
  .cpu_big_endian_o, .user_endian_swap_o, .link_reservation_flag_o, .fpr_width_select_o,
  .fpu_condition_code_o, .trap_valid_o, .trap_code_o, .trap_restart_o
);

// >>> verification/cas_exec_model.sv
// Purpose: Far-side model feeding retiring instructions to the state block
// Assumes: One record per clock
// Notes:   Idle cycles carry an all-zero record so nothing stale retires
`timescale 1ns/1ps
module cas_exec_model (
  input  wire logic                 core_clk_i,
  input  wire cas_pkg::cas_retire_t rec_i,
  output cas_pkg::cas_retire_t      retire_o
);
  always_ff @(posedge core_clk_i) begin
    retire_o <= rec_i;
  end
endmodule

// >>> verification/test_cpu_architectural_state.sv
// Purpose: Directed test of the architectural state block
// Assumes: Two shadow sets, strap high through reset
// Notes:   PC and restart values are worked out here by hand
`timescale 1ns/1ps
module test_cpu_architectural_state;
  logic                 core_clk;
  logic                 resetn = 1'b0;
  logic                 clk_en = 1'b1;
  logic                 strap = 1'b1;
  logic                 current_shadow_set = 1'b0;
  logic                 rev = 1'b0;
  logic                 user = 1'b0;
  logic                 fr = 1'b0;
  logic                 coproc_condition_signal = 1'b0;
  logic                 we = 1'b0;
  logic [4:0]           ra = 5'h00;
  logic [4:0]           wi = 5'h00;
  logic [31:0]          wd = 32'h00000000;
  cas_pkg::cas_retire_t rec = '0;
  cas_pkg::cas_retire_t ret;
  cas_pkg::cas_trap_t   trap = '0;
  logic [31:0]          rda, rdb, pc, ppc, targ, trst;
  logic [4:0]           tcode;
  logic                 mode, dly, meb, ceb, swp, llf, csok, fpr, fcc, tval;
  int                   err_total = 0;
  int                   samples_checked = 0;
  int                   cyc = 0;

  cas_exec_model u_exec (.core_clk_i(core_clk), .rec_i(rec), .retire_o(ret));
  cas_core_state DUT (
    .core_clk_i(core_clk), .resetn_i(resetn), .clk_en_i(clk_en), .cfg_big_endian_i(strap),
    .current_shadow_set_i(current_shadow_set), .reverse_endian_bit_i(rev), .user_mode_i(user),
    .float_reg_width_bit_i(fr), .coproc_condition_signal_i(coproc_condition_signal), .rd_a_idx_i(ra),
    .rd_b_idx_i(ra), .wr_en_i(we), .wr_idx_i(wi), .wr_data_i(wd), .retire_i(ret),
    .trap_i(trap), .rd_a_data_o(rda), .rd_b_data_o(rdb), .pc_o(pc), .phys_pc_o(ppc),
    .instruction_width_mode_o(mode), .in_delay_slot_flag_o(dly), .mem_big_endian_o(meb),
    .cpu_big_endian_o(ceb), .user_endian_swap_o(swp), .link_reservation_flag_o(llf),
    .cond_store_ok_o(csok), .fpr_width_select_o(fpr), .fpu_condition_code_o(fcc),
    .trap_valid_o(tval), .trap_code_o(tcode), .trap_arg_o(targ), .trap_restart_o(trst)
  );

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_val({31'h0, got}, {31'h0, exp});
  endtask

  task automatic finish_test();
    $display("checked=%0d mismatches=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Kinds: 0 wide, 1 short, 2 jump, 3 branch, 4 link, 5 mode, 6 linked, 7 cond, 8 eret, 9 break
  function automatic cas_pkg::cas_retire_t ins(input logic [3:0] k, input logic [31:0] v);
    cas_pkg::cas_retire_t r;
    r = '0;
    r.valid = 1'b1;
    r.pc_value = v;
    r.branch_target = v;
    r.link_reg = v[4:0];
    r.mode_value = v[0];
    case (k)
      4'h1: r.short_insn = 1'b1;
      4'h2: r.pc_assign = 1'b1;
      4'h3: r.branch_taken = 1'b1;
      4'h4: r.link_write = 1'b1;
      4'h5: r.mode_assign = 1'b1;
      4'h6: r.linked_load = 1'b1;
      4'h7: r.cond_store = 1'b1;
      4'h8: r.exc_return = 1'b1;
      4'h9: r.break_atomic = 1'b1;
      default: r.valid = 1'b1;
    endcase
    return r;
  endfunction

  task automatic step(input cas_pkg::cas_retire_t r);
    @(posedge core_clk);
    rec <= r;
  endtask

  // Last record reaches the design one edge after it is handed over and shows in its state after the second
  task automatic flush();
    step('0);
    @(posedge core_clk);
    #1;
  endtask

  task automatic wr(input logic [4:0] i, input logic [31:0] d);
    @(posedge core_clk);
    we <= 1'b1;
    wi <= i;
    wd <= d;
    @(posedge core_clk);
    we <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] i, input logic [31:0] e);
    @(posedge core_clk);
    ra <= i;
    @(posedge core_clk);
    #1;
    chk_val(rda, e);
    chk_val(rdb, e);
  endtask

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      finish_test();
    end
  end

  initial begin
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (5) @(posedge core_clk);
    #1;
    chk_val(pc, 32'h00000000);
    chk_bit(meb, 1'b1);
    chk_bit(mode, 1'b0);
    $display("test reset done");
    wr(5'h03, 32'h0000A5A5);
    current_shadow_set <= 1'b1;
    wr(5'h03, 32'h00005A5A);
    wr(5'h00, 32'hFFFFFFFF);
    rd(5'h03, 32'h00005A5A);
    rd(5'h00, 32'h00000000);
    current_shadow_set <= 1'b0;
    rd(5'h03, 32'h0000A5A5);
    $display("test registers done");
    step(ins(4'h0, '0));
    step(ins(4'h1, '0));
    step(ins(4'h1, '0));
    flush();
    chk_val(pc, 32'h00000008);
    step(ins(4'h2, 32'h00000100));
    step(ins(4'h3, 32'h00000200));
    flush();
    chk_val(pc, 32'h00000104);
    chk_bit(dly, 1'b1);
    step(ins(4'h0, '0));
    flush();
    chk_val(pc, 32'h00000200);
    chk_val(ppc, 32'h00000200);
    chk_bit(dly, 1'b0);
    $display("test sequencing done");
    step(ins(4'h5, 32'h00000001));
    step(ins(4'h4, 32'h00000005));
    flush();
    chk_bit(mode, 1'b1);
    rd(5'h05, 32'h00000205);
    $display("test link done");
    step(ins(4'h6, '0));
    flush();
    chk_bit(llf, 1'b1);
    chk_bit(csok, 1'b1);
    step(ins(4'h8, '0));
    step(ins(4'h6, '0));
    step(ins(4'h7, '0));
    flush();
    chk_bit(llf, 1'b0);
    step(ins(4'h6, '0));
    step(ins(4'h9, '0));
    flush();
    chk_bit(llf, 1'b0);
    $display("test reservation done");
    @(posedge core_clk);
    trap <= '{raise: 1'b1, code: 5'h0C, arg: 32'hCAFE0001};
    @(posedge core_clk);
    trap <= '0;
    #1;
    chk_bit(tval, 1'b1);
    chk_val({27'h0, tcode}, 32'h0000000C);
    chk_val(targ, 32'hCAFE0001);
    chk_val(trst, 32'h00000221);
    $display("test trap done");
    clk_en <= 1'b0;
    strap <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      {rev, user} <= i[1:0];
      fr <= i[0];
      coproc_condition_signal <= i[1];
      @(posedge core_clk);
      #1;
      chk_bit(swp, i == 3);
      chk_bit(ceb, i != 3);
      chk_bit(fpr, i[0]);
      chk_bit(fcc, i[1]);
    end
    clk_en <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    chk_bit(meb, 1'b1);
    $display("test endian done");
    finish_test();
  end
endmodule
